// [ifd_decoder.sv]
// holds the instruction format decoder for the multithreaded core
// assumes words come from fetch synchronous to clk; results feed execute

`timescale 1ns/1ns

module ifd_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // word from fetch
    input wire logic word_valid,
    input wire logic [ifd_pkg::WORD_W-1:0] word,
    // decoded class and routing
    output logic dec_valid,
    output ifd_pkg::ifd_format_type format_class,
    output ifd_pkg::ifd_route_type route,
    output logic unimplemented,
    // code fields
    output logic [3:0] primary_code_field,
    output logic [1:0] wide_imm_subcode,
    output logic [3:0] twelve_imm_subcode,
    output logic [2:0] five_imm_subcode,
    output logic [5:0] reg_format_subcode,
    // register indices
    output logic [5:0] reg_a,
    output logic [5:0] reg_b,
    output logic [5:0] reg_c,
    output logic [5:0] dst_reg,
    output logic dst_write,
    output logic src2_is_imm,
    // immediate fields
    output logic [19:0] imm_twenty,
    output logic [25:0] jump_target_field,
    output logic [15:0] imm_sixteen,
    output logic [11:0] imm_twelve,
    output logic [4:0] imm_five,
    output logic [ifd_pkg::WORD_W-1:0] operand_imm,
    // special operations
    output logic is_call,
    output logic is_jump_abs,
    output logic is_load_upper,
    output logic [4:0] shift_amount,
    output logic [4:0] range_high,
    output logic [4:0] range_low,
    output logic range_ordered
);
    import ifd_pkg::*;

    //======================================================================
    // raw field slicing, valid for whichever format applies
    wire logic [3:0] w_primary = word[PRIMARY_MSB:PRIMARY_LSB];
    wire logic [5:0] w_reg_a = word[REG_A_MSB:REG_A_LSB];
    wire logic [5:0] w_reg_b = word[REG_B_MSB:REG_B_LSB];
    wire logic [5:0] w_reg_c = word[REG_C_MSB:REG_C_LSB];
    wire logic [1:0] w_wide_sub = word[WIDE_SUB_MSB:WIDE_SUB_LSB];
    wire logic [19:0] w_imm_twenty = word[IMM_TWENTY_MSB:0];
    wire logic [15:0] w_imm_sixteen = word[IMM_SIXTEEN_MSB:0];
    wire logic [3:0] w_twelve_sub = word[TWELVE_SUB_MSB:TWELVE_SUB_LSB];
    wire logic [11:0] w_imm_twelve = word[IMM_TWELVE_MSB:0];
    wire logic [2:0] w_five_sub = word[FIVE_SUB_MSB:FIVE_SUB_LSB];
    wire logic [4:0] w_imm_five = word[IMM_FIVE_MSB:0];
    wire logic [5:0] w_reg_sub = word[REG_SUB_MSB:0];
    // bits 11:10 are not looked at in the range form
    wire logic [4:0] w_range_hi = word[RANGE_HI_MSB:RANGE_HI_LSB];
    wire logic [4:0] w_range_lo = word[RANGE_LO_MSB:0];

    // jump target: register field becomes the upper six target bits
    wire logic [25:0] w_jump_target = {w_reg_a, w_imm_twenty};

    //======================================================================
    // primary code classification
    wire logic pc_wide = (w_primary == PC_WIDE);
    wire logic pc_twelve_a = (w_primary == PC_TWELVE_A);
    wire logic pc_twelve_b = (w_primary == PC_TWELVE_B);
    wire logic pc_three = (w_primary == PC_THREE_REG);
    wire logic pc_send = (w_primary == PC_SEND_IMM);
    wire logic pc_logic = (w_primary >= PC_LOGIC_FIRST);
    wire logic pc_sixteen = pc_send | pc_logic;

    // five-immediate words hide under primary 0x1, subcode 0x0
    wire logic sub_five = pc_twelve_a & (w_twelve_sub == TA_FIVE_IMM);
    // bitfield words hide under primary 0x2, subcodes 0xC, 0xE, 0xF
    wire logic sub_insert = pc_twelve_b & (w_twelve_sub == TB_INSERT);
    wire logic sub_extract = pc_twelve_b & (w_twelve_sub == TB_EXTRACT);
    wire logic sub_merge = pc_twelve_b & (w_twelve_sub == TB_MERGE);
    wire logic sub_bitfield = sub_insert | sub_extract | sub_merge;

    // wide subcode meaning
    wire logic w_call = pc_wide & (w_wide_sub == WS_CALL);
    wire logic w_jump = pc_wide & (w_wide_sub == WS_JUMP_ABS);
    wire logic w_upper = pc_wide & (w_wide_sub == WS_LOAD_UPPER);

    // five-immediate amount users
    wire logic five_rotate = sub_five & (w_five_sub == FS_ROTATE_LEFT);
    wire logic five_shift = sub_five & (w_five_sub == FS_SHIFT_LEFT);

    //======================================================================
    // unassigned code detection; table holes reach execute with unimplemented set and dst_write held low
    wire logic bad_primary = ~(pc_wide | pc_twelve_a | pc_twelve_b | pc_three | pc_sixteen);
    wire logic bad_wide = pc_wide & ~(w_call | w_jump | w_upper);
    wire logic bad_twelve_a = pc_twelve_a & ~TA_USED_MASK[w_twelve_sub];
    wire logic bad_twelve_b = pc_twelve_b & ~TB_USED_MASK[w_twelve_sub];
    wire logic [63:0] reg_used = REG_USED_MASK | REG_USED_EXTRA;
    wire logic bad_three = pc_three & ~reg_used[w_reg_sub];
    // further five subcodes other than the two amounts have no table here
    wire logic bad_five = sub_five & ~(five_rotate | five_shift);
    wire logic next_unimpl = bad_primary | bad_wide | bad_twelve_a | bad_twelve_b
        | bad_three | bad_five;

    //======================================================================
    // format class; the six classes are mutually exclusive
    ifd_format_type next_format;
    always_comb begin
        next_format = IFD_FMT_NONE;
        if (pc_wide) begin
            next_format = IFD_FMT_WIDE;
        end else if (sub_five) begin
            next_format = IFD_FMT_FIVE;
        end else if (sub_bitfield) begin
            next_format = IFD_FMT_BITFIELD;
        end else if (pc_twelve_a | pc_twelve_b) begin
            next_format = IFD_FMT_TWELVE;
        end else if (pc_three) begin
            next_format = IFD_FMT_THREE_REG;
        end else if (pc_sixteen) begin
            next_format = IFD_FMT_SIXTEEN;
        end
    end

    //======================================================================
    // route class for execute
    wire logic ta_branch = pc_twelve_a & (w_twelve_sub >= TA_BR_FIRST);
    wire logic tb_store = pc_twelve_b & (w_twelve_sub >= TB_STORE_FIRST)
        & (w_twelve_sub < TB_MUL_IMM);
    wire logic tb_arith = pc_twelve_b & ((w_twelve_sub == TB_ADD_IMM)
        | (w_twelve_sub == TB_MUL_IMM));

    ifd_route_type next_route;
    always_comb begin
        next_route = IFD_RT_NONE;
        case (next_format)
            IFD_FMT_WIDE: begin
                next_route = w_upper ? IFD_RT_ARITH : IFD_RT_CONTROL;
            end
            IFD_FMT_SIXTEEN: begin
                next_route = pc_send ? IFD_RT_SEND : IFD_RT_LOGIC;
            end
            IFD_FMT_TWELVE: begin
                if (ta_branch) begin
                    next_route = IFD_RT_BRANCH;
                end else if (pc_twelve_a) begin
                    next_route = IFD_RT_COMPARE;
                end else if (tb_arith) begin
                    next_route = IFD_RT_ARITH;
                end else if (tb_store) begin
                    next_route = IFD_RT_STORE;
                end else begin
                    next_route = IFD_RT_LOAD;
                end
            end
            IFD_FMT_FIVE: begin
                next_route = IFD_RT_SHIFT;
            end
            IFD_FMT_THREE_REG: begin
                next_route = IFD_RT_ARITH;
            end
            IFD_FMT_BITFIELD: begin
                next_route = IFD_RT_BITFIELD;
            end
            default: begin
                next_route = IFD_RT_NONE;
            end
        endcase
    end

    //======================================================================
    // extension choice: logical ops and unsigned compares zero-extend
    wire logic unsigned_twelve = pc_twelve_a & ((w_twelve_sub == TA_CMP_GEU)
        | (w_twelve_sub == TA_CMP_LTU) | (w_twelve_sub == TA_BR_GEU)
        | (w_twelve_sub == TA_BR_LTU));
    wire logic sixteen_signed = ~pc_logic;
    wire logic twelve_signed = ~unsigned_twelve;

    wire logic [WORD_W-1:0] ext_sixteen;
    wire logic [WORD_W-1:0] ext_twelve;

    ifd_operand_extend #(
        .IN_W(16)
    ) u_ext_sixteen (
        .narrow(w_imm_sixteen),
        .use_sign(sixteen_signed),
        .wide(ext_sixteen)
    );

    ifd_operand_extend #(
        .IN_W(12)
    ) u_ext_twelve (
        .narrow(w_imm_twelve),
        .use_sign(twelve_signed),
        .wide(ext_twelve)
    );

    // upper load places the twenty bits above twelve zeros
    wire logic [WORD_W-1:0] upper_value = {w_imm_twenty, {UPPER_SHIFT{1'b0}}};
    wire logic [WORD_W-1:0] five_value = {{(WORD_W-5){1'b0}}, w_imm_five};

    // three-register and bitfield carry no numeric constant
    wire logic [WORD_W-1:0] next_operand =
        (next_format == IFD_FMT_SIXTEEN) ? ext_sixteen :
        (next_format == IFD_FMT_TWELVE) ? ext_twelve :
        (next_format == IFD_FMT_FIVE) ? five_value :
        (next_format == IFD_FMT_WIDE && w_upper) ? upper_value :
        '0;
    wire logic next_src2_imm = (next_format == IFD_FMT_SIXTEEN)
        | (next_format == IFD_FMT_TWELVE) | (next_format == IFD_FMT_FIVE);

    //======================================================================
    // destination selection
    wire logic no_write = (next_route == IFD_RT_BRANCH) | (next_route == IFD_RT_STORE)
        | (next_route == IFD_RT_SEND) | w_jump | next_unimpl
        | (next_format == IFD_FMT_NONE);
    wire logic [5:0] next_dst = (next_format == IFD_FMT_THREE_REG) ? w_reg_c :
        (next_format == IFD_FMT_WIDE) ? w_reg_a : w_reg_b;

    // range is usable only when high is not below low
    wire logic next_ordered = (w_range_hi >= w_range_lo);

    //======================================================================
    // class and routing registers; one cycle of decode latency
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_valid <= 1'b0;
            format_class <= IFD_FMT_NONE;
            route <= IFD_RT_NONE;
            unimplemented <= 1'b0;
        end else begin
            dec_valid <= word_valid;
            format_class <= next_format;
            route <= next_route;
            unimplemented <= word_valid & next_unimpl;
        end
    end

    // code field and register index registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            primary_code_field <= 4'h0;
            wide_imm_subcode <= 2'h0;
            twelve_imm_subcode <= 4'h0;
            five_imm_subcode <= 3'h0;
            reg_format_subcode <= 6'h00;
            reg_a <= 6'h00;
            reg_b <= 6'h00;
            reg_c <= 6'h00;
            dst_reg <= 6'h00;
            dst_write <= 1'b0;
            src2_is_imm <= 1'b0;
        end else begin
            primary_code_field <= w_primary;
            wide_imm_subcode <= w_wide_sub;
            twelve_imm_subcode <= w_twelve_sub;
            five_imm_subcode <= w_five_sub;
            reg_format_subcode <= w_reg_sub;
            reg_a <= w_reg_a;
            reg_b <= w_reg_b;
            reg_c <= w_reg_c;
            dst_reg <= next_dst;
            dst_write <= word_valid & ~no_write;
            src2_is_imm <= next_src2_imm;
        end
    end

    // immediate registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            imm_twenty <= 20'h00000;
            jump_target_field <= 26'h0000000;
            imm_sixteen <= 16'h0000;
            imm_twelve <= 12'h000;
            imm_five <= 5'h00;
            operand_imm <= 32'h00000000;
        end else begin
            imm_twenty <= w_imm_twenty;
            jump_target_field <= w_jump_target;
            imm_sixteen <= w_imm_sixteen;
            imm_twelve <= w_imm_twelve;
            imm_five <= w_imm_five;
            operand_imm <= next_operand;
        end
    end

    // special-operation registers; only the three flags are qualified by valid, amounts and ranges are not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            is_call <= 1'b0;
            is_jump_abs <= 1'b0;
            is_load_upper <= 1'b0;
            shift_amount <= 5'h00;
            range_high <= 5'h00;
            range_low <= 5'h00;
            range_ordered <= 1'b0;
        end else begin
            is_call <= word_valid & w_call;
            is_jump_abs <= word_valid & w_jump;
            is_load_upper <= word_valid & w_upper;
            shift_amount <= (five_rotate | five_shift) ? w_imm_five : 5'h00;
            range_high <= w_range_hi;
            range_low <= w_range_lo;
            range_ordered <= sub_bitfield & next_ordered;
        end
    end
endmodule : ifd_decoder

// [ifd_decoder_sva.sv]
// port checker for the instruction format decoder
// assumes it is bound to ifd_decoder and sees only that module's ports
`timescale 1ns/1ns

//==========================================================================
// decoder port checker
module ifd_decoder_sva (
    // clock, reset and fetched word
    input wire logic clk,
    input wire logic arst_n,
    input wire logic word_valid,
    input wire logic [31:0] word,
    // decoded outputs
    input wire logic dec_valid,
    input ifd_pkg::ifd_format_type format_class,
    input wire logic unimplemented,
    input wire logic [3:0] primary_code_field,
    input wire logic [2:0] five_imm_subcode,
    input wire logic [5:0] reg_a,
    input wire logic [5:0] reg_b,
    input wire logic [5:0] reg_c,
    input wire logic [5:0] dst_reg,
    input wire logic dst_write,
    input wire logic src2_is_imm,
    input wire logic [19:0] imm_twenty,
    input wire logic [25:0] jump_target_field,
    input wire logic [15:0] imm_sixteen,
    input wire logic [11:0] imm_twelve,
    input wire logic [4:0] imm_five,
    input wire logic [31:0] operand_imm,
    input wire logic is_jump_abs,
    input wire logic is_load_upper,
    input wire logic [4:0] shift_amount,
    input wire logic [4:0] range_high,
    input wire logic [4:0] range_low,
    input wire logic range_ordered
);
    import ifd_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // a real word carrying a given primary code
    sequence s_code(logic [3:0] pc);
        word_valid && word[31:28] == pc;
    endsequence

    // fields follow the word of the previous edge
    property p_fields;
        logic [31:0] w;
        (word_valid, w = word) |=> primary_code_field == w[31:28] && reg_a == w[27:22]
            && reg_b == w[21:16] && reg_c == w[15:10];
    endproperty

    // upper load puts the value at the top
    property p_upper;
        logic [19:0] v;
        (s_code(4'h0) ##0 (word[21:20] == 2'h2, v = word[19:0]))
            |=> is_load_upper && operand_imm == {v, 12'h000};
    endproperty

    valid_follow_a: assert property (1'b1 |=> dec_valid == $past(word_valid))
        else $error("valid not delayed");
    field_slice_a: assert property (p_fields)
        else $error("field slices wrong");
    jump_join_a: assert property (is_jump_abs |-> jump_target_field == {reg_a, imm_twenty})
        else $error("jump target not joined");
    upper_load_a: assert property (p_upper)
        else $error("upper load wrong");
    sign_extend_a: assert property (s_code(4'h4) |=> dst_reg == reg_b
        && operand_imm == {{16{imm_sixteen[15]}}, imm_sixteen}) else $error("sixteen sign ext");
    shift_amount_a: assert property (dec_valid && format_class == IFD_FMT_FIVE
        && five_imm_subcode <= 3'h1 |-> shift_amount == imm_five && src2_is_imm)
        else $error("shift amount wrong");
    three_reg_a: assert property (format_class == IFD_FMT_THREE_REG
        |-> !src2_is_imm && dst_reg == reg_c) else $error("three-register operands");
    range_split_a: assert property (format_class == IFD_FMT_BITFIELD
        |-> range_high == imm_twelve[9:5] && range_low == imm_twelve[4:0]
        && range_ordered == (range_high >= range_low)) else $error("range fields wrong");
    bitfield_pick_a: assert property (s_code(4'h2) ##0 word[15:12] inside {4'hC, 4'hE, 4'hF}
        |=> format_class == IFD_FMT_BITFIELD) else $error("bitfield not chosen");
    unassigned_flag_a: assert property (word_valid && word[31:28] inside {[4'h5:4'h7]}
        |=> unimplemented && !dst_write) else $error("unassigned code not flagged");
endmodule : ifd_decoder_sva

bind ifd_decoder ifd_decoder_sva ifd_decoder_sva_inst (.*);

// [ifd_fetch_model.sv]
// fetch stage stand-in that hands words to the decoder
// assumes the bench changes its request just after a falling edge
`timescale 1ns/1ns

//==========================================================================
// fetch model
module ifd_fetch_model (
    // clock and request from the bench
    input wire logic clk,
    input wire logic req_valid,
    input wire logic [31:0] req_word,
    // words toward the decoder
    output logic word_valid,
    output logic [31:0] word
);
    logic [31:0] last_word = 32'h0000_0000;

    // bubbles carry the inverse of the last word
    always_ff @(posedge clk) begin
        last_word <= word;
    end
    assign word_valid = req_valid;
    assign word = req_valid ? req_word : ~last_word;
endmodule : ifd_fetch_model

// [ifd_support.sv]
// holds the shared decoder constants and types, and the immediate extender
// assumes a single 100 MHz clock domain; nothing here is clocked

//==========================================================================
// shared constants and types
package ifd_pkg;
    // clock and cycle figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int DECODE_LATENCY_CYCLES = 1;

    // field positions inside the 32-bit word
    localparam int WORD_W = 32;
    localparam int PRIMARY_MSB = 31;
    localparam int PRIMARY_LSB = 28;
    localparam int REG_A_MSB = 27;
    localparam int REG_A_LSB = 22;
    localparam int REG_B_MSB = 21;
    localparam int REG_B_LSB = 16;
    localparam int REG_C_MSB = 15;
    localparam int REG_C_LSB = 10;
    localparam int WIDE_SUB_MSB = 21;
    localparam int WIDE_SUB_LSB = 20;
    localparam int IMM_TWENTY_MSB = 19;
    localparam int IMM_SIXTEEN_MSB = 15;
    localparam int TWELVE_SUB_MSB = 15;
    localparam int TWELVE_SUB_LSB = 12;
    localparam int IMM_TWELVE_MSB = 11;
    localparam int FIVE_SUB_MSB = 7;
    localparam int FIVE_SUB_LSB = 5;
    localparam int IMM_FIVE_MSB = 4;
    localparam int RANGE_HI_MSB = 9;
    localparam int RANGE_HI_LSB = 5;
    localparam int RANGE_LO_MSB = 4;
    localparam int REG_SUB_MSB = 5;
    localparam int UPPER_SHIFT = 12;

    // primary codes
    localparam logic [3:0] PC_WIDE = 4'h0;
    localparam logic [3:0] PC_TWELVE_A = 4'h1;
    localparam logic [3:0] PC_TWELVE_B = 4'h2;
    localparam logic [3:0] PC_THREE_REG = 4'h3;
    localparam logic [3:0] PC_SEND_IMM = 4'h4;
    localparam logic [3:0] PC_LOGIC_FIRST = 4'h8;

    // wide-immediate subcodes
    localparam logic [1:0] WS_CALL = 2'h0;
    localparam logic [1:0] WS_JUMP_ABS = 2'h1;
    localparam logic [1:0] WS_LOAD_UPPER = 2'h2;

    // twelve-immediate subcodes under primary 0x1
    localparam logic [3:0] TA_FIVE_IMM = 4'h0;
    localparam logic [3:0] TA_CMP_GEU = 4'h5;
    localparam logic [3:0] TA_CMP_LTU = 4'h6;
    localparam logic [3:0] TA_BR_FIRST = 4'h9;
    localparam logic [3:0] TA_BR_GEU = 4'hD;
    localparam logic [3:0] TA_BR_LTU = 4'hE;
    // bit set = subcode assigned
    localparam logic [15:0] TA_USED_MASK = 16'h7E7F;

    // twelve-immediate subcodes under primary 0x2
    localparam logic [3:0] TB_ADD_IMM = 4'h3;
    localparam logic [3:0] TB_MUL_IMM = 4'hB;
    localparam logic [3:0] TB_STORE_FIRST = 4'h8;
    localparam logic [3:0] TB_INSERT = 4'hC;
    localparam logic [3:0] TB_EXTRACT = 4'hE;
    localparam logic [3:0] TB_MERGE = 4'hF;
    localparam logic [15:0] TB_USED_MASK = 16'hDF3F;

    // three-register subcodes in use, bit n = subcode n
    localparam logic [63:0] REG_USED_MASK = 64'h0227_41C1_F1F5_77F2;
    // nothing beyond the table; 0x24, 0x3A..0x3F and gaps count as unimplemented
    localparam logic [63:0] REG_USED_EXTRA = 64'h0000_0000_0000_0000;

    // five-immediate further subcodes: rotate-left and shift-left amounts
    localparam logic [2:0] FS_ROTATE_LEFT = 3'h0;
    localparam logic [2:0] FS_SHIFT_LEFT = 3'h1;

    typedef enum logic [2:0] {
        IFD_FMT_NONE,
        IFD_FMT_WIDE,
        IFD_FMT_SIXTEEN,
        IFD_FMT_TWELVE,
        IFD_FMT_FIVE,
        IFD_FMT_THREE_REG,
        IFD_FMT_BITFIELD
    } ifd_format_type;

    typedef enum logic [3:0] {
        IFD_RT_NONE,
        IFD_RT_ARITH,
        IFD_RT_LOGIC,
        IFD_RT_COMPARE,
        IFD_RT_BRANCH,
        IFD_RT_LOAD,
        IFD_RT_STORE,
        IFD_RT_SHIFT,
        IFD_RT_BITFIELD,
        IFD_RT_CONTROL,
        IFD_RT_SEND
    } ifd_route_type;
endpackage : ifd_pkg

`timescale 1ns/1ns

//==========================================================================
// immediate extender: sign or zero, chosen by the caller
module ifd_operand_extend #(
    parameter int IN_W = 16
) (
    // narrow field and choice
    input wire logic [IN_W-1:0] narrow,
    input wire logic use_sign,
    // widened operand
    output logic [ifd_pkg::WORD_W-1:0] wide
);
    import ifd_pkg::*;

    // top bit replicated only when signed
    wire logic fill_bit = use_sign & narrow[IN_W-1];
    assign wide = {{(WORD_W-IN_W){fill_bit}}, narrow};
endmodule : ifd_operand_extend

// [tb.sv]
// self-checking bench for the instruction format decoder
// assumes a one-cycle decode pipeline and a 100 MHz clock
`timescale 1ns/1ns

//==========================================================================
// bench top
module tb;
    import ifd_pkg::*;

    logic clk = 1'b0;
    logic arst_n, req_valid, word_valid, dec_valid, unimplemented, dst_write, src2_is_imm;
    logic is_call, is_jump_abs, is_load_upper, range_ordered;
    logic [31:0] req_word, word, operand_imm, r;
    logic [3:0] primary_code_field, twelve_imm_subcode;
    logic [1:0] wide_imm_subcode;
    logic [2:0] five_imm_subcode;
    logic [5:0] reg_format_subcode, reg_a, reg_b, reg_c, dst_reg;
    logic [19:0] imm_twenty;
    logic [25:0] jump_target_field;
    logic [15:0] imm_sixteen;
    logic [11:0] imm_twelve;
    logic [4:0] imm_five, shift_amount, range_high, range_low;
    ifd_format_type format_class;
    ifd_route_type route;
    int fail_count = 0;
    int n_compared = 0;
    int i;
    integer seed;

    always #5 clk = ~clk;

    ifd_fetch_model ifd_fetch_model_inst (.*);
    ifd_decoder ifd_decoder_inst (.*);

    //======================================================================
    // expectations
    function automatic logic exp_unimpl(logic [31:0] w);
        case (w[31:28])
            4'h0: return w[21:20] == 2'h3;
            4'h1: return w[15:12] inside {4'h7, 4'h8, 4'hF} || (w[15:12] == 4'h0 && w[7:5] > 3'h1);
            4'h2: return w[15:12] inside {4'h6, 4'h7, 4'hD};
            4'h3: return !REG_USED_MASK[w[5:0]];
            default: return w[31:28] inside {[4'h5:4'h7]};
        endcase
    endfunction : exp_unimpl

    function automatic ifd_format_type exp_fmt(logic [31:0] w);
        case (w[31:28])
            4'h0: return IFD_FMT_WIDE;
            4'h1: return w[15:12] == 4'h0 ? IFD_FMT_FIVE : IFD_FMT_TWELVE;
            4'h2: return w[15:12] inside {4'hC, 4'hE, 4'hF} ? IFD_FMT_BITFIELD : IFD_FMT_TWELVE;
            4'h3: return IFD_FMT_THREE_REG;
            4'h5, 4'h6, 4'h7: return IFD_FMT_NONE;
            default: return IFD_FMT_SIXTEEN;
        endcase
    endfunction : exp_fmt

    // unsigned compares and branches under primary 0x1 take zero extension
    function automatic logic [31:0] exp_imm(logic [31:0] w);
        logic zx;
        zx = w[31:28] == 4'h1 && w[15:12] inside {4'h5, 4'h6, 4'hD, 4'hE};
        case (exp_fmt(w))
            IFD_FMT_SIXTEEN: return w[31] ? {16'h0000, w[15:0]} : {{16{w[15]}}, w[15:0]};
            IFD_FMT_TWELVE: return zx ? {20'h00000, w[11:0]} : {{20{w[11]}}, w[11:0]};
            IFD_FMT_FIVE: return {27'h0000000, w[4:0]};
            IFD_FMT_WIDE: return w[21:20] == 2'h2 ? {w[19:0], 12'h000} : 32'h0000_0000;
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_imm

    function automatic ifd_route_type exp_route(logic [31:0] w);
        if (w[31:28] == 4'h1) begin
            return w[15:12] >= 4'h9 ? IFD_RT_BRANCH : IFD_RT_COMPARE;
        end
        if (w[15:12] inside {4'h3, 4'hB}) begin
            return IFD_RT_ARITH;
        end
        return w[15:12] inside {[4'h8:4'hA]} ? IFD_RT_STORE : IFD_RT_LOAD;
    endfunction : exp_route

    //======================================================================
    // compare, drive and close
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // one word per cycle, results looked at one edge later
    task automatic apply(input logic v, input logic [31:0] w);
        logic u;
        ifd_format_type f;
        @(negedge clk);
        req_valid = v;
        req_word = w;
        @(posedge clk);
        #1;
        u = exp_unimpl(w);
        f = exp_fmt(w);
        check(32'(dec_valid), 32'(v));
        if (!v) begin
            check(32'({is_call, is_jump_abs, is_load_upper, dst_write, unimplemented}), 0);
            return;
        end
        check(32'(primary_code_field), 32'(w[31:28]));
        check(32'({reg_a, reg_b, reg_c}), 32'(w[27:10]));
        check(32'({wide_imm_subcode, imm_twenty}), 32'(w[21:0]));
        check(32'({twelve_imm_subcode, imm_twelve}), 32'(w[15:0]));
        check(32'({five_imm_subcode, imm_five, reg_format_subcode}), 32'({w[7:0], w[5:0]}));
        check(32'(jump_target_field), 32'({w[27:22], w[19:0]}));
        check(32'({range_high, range_low}), 32'(w[9:0]));
        check(32'(unimplemented), 32'(u));
        check(32'({is_call, is_jump_abs, is_load_upper}), (w[31:28] != 4'h0) ? 0
            : 32'({w[21:20] == 2'h0, w[21:20] == 2'h1, w[21:20] == 2'h2}));
        if (u) begin
            return;
        end
        check(32'(format_class), 32'(f));
        check(32'(src2_is_imm), 32'(f inside {IFD_FMT_SIXTEEN, IFD_FMT_TWELVE, IFD_FMT_FIVE}));
        check(32'(dst_reg), 32'(f == IFD_FMT_THREE_REG ? w[15:10]
            : f == IFD_FMT_WIDE ? w[27:22] : w[21:16]));
        check(32'(shift_amount), (f == IFD_FMT_FIVE) ? 32'(w[4:0]) : 0);
        check(32'(range_ordered), 32'(f == IFD_FMT_BITFIELD && w[9:5] >= w[4:0]));
        if (f == IFD_FMT_TWELVE) begin
            check(32'(route), 32'(exp_route(w)));
        end
        check(operand_imm, exp_imm(w));
        check(32'(dst_write), 32'(w[31:28] != 4'h4
            && !(f == IFD_FMT_WIDE && w[21:20] == 2'h1)
            && !(f == IFD_FMT_TWELVE && exp_route(w) inside {IFD_RT_BRANCH, IFD_RT_STORE})));
    endtask : apply

    //======================================================================
    // hang guard
    initial begin
        #100000;
        fail_count++;
        $display("Error at %0t ns: hang", $time);
        tally_and_finish();
    end

    //======================================================================
    // main sequence
    initial begin
        seed = 32'h4c83c435;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_word = 32'h0000_0000;
        repeat (6) @(posedge clk);
        #1;
        check(32'({dec_valid, unimplemented, format_class}), 0);
        @(negedge clk);
        arst_n = 1'b1;
        // every primary code, sign boundary of the sixteen-bit field
        for (i = 0; i < 16; i++) apply(1'b1, {i[3:0], 12'hFC1, 16'h8001});
        for (i = 0; i < 4; i++) apply(1'b1, {4'h0, 6'h2A, i[1:0], 20'h80F0F});
        // every twelve subcode, both primaries
        for (i = 0; i < 32; i++) apply(1'b1, {2'b00, i[4], ~i[4], 12'h5A7, i[3:0], 12'h8A3});
        for (i = 0; i < 8; i++) apply(1'b1, {4'h1, 12'hABC, 8'h00, i[2:0], 5'h1F});
        for (i = 0; i < 64; i++) apply(1'b1, {4'h3, 18'h24C5A, 4'h0, i[5:0]});
        apply(1'b0, 32'h1234_5678);
        apply(1'b1, 32'h2000_E3E1);
        // random words with bubbles mixed in
        repeat (600) begin
            r = $random(seed);
            apply(r[0] | r[1], $random(seed));
        end
        // mid-run reset, word driven one cycle after release
        @(negedge clk);
        arst_n = 1'b0;
        #1;
        check(32'({dec_valid, is_call, is_jump_abs, dst_write}), 0);
        @(negedge clk);
        arst_n = 1'b1;
        apply(1'b1, 32'h0100_0000);
        apply(1'b1, 32'hF7FF_FFFF);
        tally_and_finish();
    end
endmodule : tb
